// file: inc/irc_params.svh
// Numeric constants of the infrared pulse encoder/decoder
`ifndef IRC_PARAMS_SVH
`define IRC_PARAMS_SVH

`define IRC_CLK_HZ        50_000_000
`define IRC_CNT_W         16
`define IRC_PULSE_FIX_NS  1627
`define IRC_NS_PER_S      1_000_000_000
`define IRC_PULSE_NUM     3
`define IRC_PULSE_DEN     16
`define IRC_RATE_RESET    4'h6
`define IRC_RATE_MAX      4'hC
`define IRC_BIT_USER_B    6
`define IRC_BIT_USER_A    5
`define IRC_BIT_PULSE     4
`define IRC_RATE_MSB      3
`define IRC_RATE_LSB      0
`define IRC_DATA_BITS     8
`define IRC_BAUD_0        115200
`define IRC_BAUD_1        57600
`define IRC_BAUD_2        38400
`define IRC_BAUD_3        19200
`define IRC_BAUD_4        14400
`define IRC_BAUD_5        12800
`define IRC_BAUD_6        9600
`define IRC_BAUD_7        7200
`define IRC_BAUD_8        4800
`define IRC_BAUD_9        3600
`define IRC_BAUD_A        2400
`define IRC_BAUD_B        1800
`define IRC_BAUD_C        1200

`endif

// file: inc/irc_pkg.sv
// Types shared by the infrared pulse encoder/decoder modules
package irc_pkg;
	typedef logic [3:0]  irc_rate_t;
	typedef logic [15:0] irc_cnt_t;
	typedef logic [7:0]  irc_byte_t;
	typedef enum logic [1:0] {CRX_IDLE, CRX_START, CRX_DATA, CRX_STOP} irc_crx_state_t;
endpackage : irc_pkg

// file: verilog/irc_cfg_rx.sv
// Asynchronous serial receiver for control bytes, 8 data bits, 1 stop bit
`include "irc_params.svh"
module irc_cfg_rx
	import irc_pkg::*;
(
	input  wire logic     clock,      // System clock
	input  wire logic     arst_n,     // Asynchronous reset, active low
	input  wire logic     ce,         // Clock enable
	input  wire logic     enable,     // Receiver armed
	input  wire logic     rx_in,      // Serial line, idle high
	input  wire irc_cnt_t bit_cycles, // Clocks per bit
	output irc_byte_t     byte_data,  // Last received byte
	output logic          byte_valid  // One-cycle pulse per good byte
);
	irc_crx_state_t state_r, state_nxt;
	irc_cnt_t       cnt_r, cnt_nxt;
	logic [2:0]     idx_r, idx_nxt;
	irc_byte_t      data_r, data_nxt;
	logic           prev_r, prev_nxt;
	logic           valid_r, valid_nxt;

	// Frame walker; samples in mid-cell so small rate error is tolerated
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		idx_nxt   = idx_r;
		data_nxt  = data_r;
		prev_nxt  = rx_in;
		valid_nxt = 1'b0;
		if (!enable) begin
			state_nxt = CRX_IDLE;
		end else begin
			case (state_r)
				CRX_IDLE: begin
					if (prev_r && !rx_in) begin
						state_nxt = CRX_START;
						cnt_nxt   = irc_cnt_t'(bit_cycles >> 1);
					end
				end
				CRX_START: begin
					if (cnt_r != '0) begin
						cnt_nxt = cnt_r - 1'b1;
					end else if (rx_in) begin
						state_nxt = CRX_IDLE; // Glitch, not a start bit
					end else begin
						state_nxt = CRX_DATA;
						cnt_nxt   = bit_cycles - 1'b1;
						idx_nxt   = '0;
					end
				end
				CRX_DATA: begin
					if (cnt_r != '0) begin
						cnt_nxt = cnt_r - 1'b1;
					end else begin
						data_nxt = {rx_in, data_r[`IRC_DATA_BITS-1:1]}; // LSB first
						cnt_nxt  = bit_cycles - 1'b1;
						idx_nxt  = idx_r + 1'b1;
						if (idx_r == 3'(`IRC_DATA_BITS - 1)) begin
							state_nxt = CRX_STOP;
						end
					end
				end
				CRX_STOP: begin
					if (cnt_r != '0) begin
						cnt_nxt = cnt_r - 1'b1;
					end else begin
						state_nxt = CRX_IDLE;
						valid_nxt = rx_in; // Framing error drops the byte
					end
				end
				default: state_nxt = CRX_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= CRX_IDLE;
			cnt_r   <= '0;
			idx_r   <= '0;
			data_r  <= '0;
			prev_r  <= 1'b1;
			valid_r <= 1'b0;
		end else if (ce) begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			idx_r   <= idx_nxt;
			data_r  <= data_nxt;
			prev_r  <= prev_nxt;
			valid_r <= valid_nxt;
		end
	end

	assign byte_data  = data_r;
	assign byte_valid = valid_r;
endmodule : irc_cfg_rx

// file: verilog/irc_ir_stretch.sv
// Receive pulse stretcher: each infrared pulse becomes one low bit cell
`include "irc_params.svh"
module irc_ir_stretch
	import irc_pkg::*;
(
	input  wire logic     clock,      // System clock
	input  wire logic     arst_n,     // Asynchronous reset, active low
	input  wire logic     ce,         // Clock enable
	input  wire logic     enable,     // Data mode active
	input  wire logic     ir_rx_in,   // Infrared receive input, active low
	input  wire irc_cnt_t bit_cycles, // Clocks per bit
	output logic          rx_out      // Stretched serial output, idle high
);
	logic     prev_r, prev_nxt;
	irc_cnt_t cnt_r, cnt_nxt;
	logic     out_r, out_nxt;

	// A new falling edge restarts the cell, so back-to-back zeros merge cleanly
	always_comb begin
		prev_nxt = ir_rx_in;
		cnt_nxt  = cnt_r;
		if (!enable) begin
			cnt_nxt = '0;
		end else if (prev_r && !ir_rx_in) begin
			cnt_nxt = bit_cycles; // see RULE24
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - 1'b1;
		end
		out_nxt = (cnt_nxt == '0); // see RULE1
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			prev_r <= 1'b1;
			cnt_r  <= '0;
			out_r  <= 1'b1;
		end else if (ce) begin
			prev_r <= prev_nxt;
			cnt_r  <= cnt_nxt;
			out_r  <= out_nxt;
		end
	end

	assign rx_out = out_r;
endmodule : irc_ir_stretch

// file: verilog/irc_endec_top.sv
// Infrared pulse encoder/decoder with serial rate and pulse configuration
// How it works
// RULE1 - Select low: transmit line goes to infrared out, infrared in to receive out.
// RULE2 - Select high: bytes on the transmit line are a control word, not data.
// RULE3 - Only the seven low bits of a control byte are used.
// RULE4 - Bit 6 user B, bit 5 user A, bit 4 pulse width, bits 3..0 rate.
// RULE5 - A new rate takes effect only when select returns low.
// RULE6 - Width bit one gives 1.627 us pulses, zero gives 3/16 bit period.
// RULE7 - User pins follow the user bits of the last accepted control word.
// RULE8 - User pins are active low; a one bit drives the pin low.
// RULE9 - Rate codes 0..C map 115.2k down to 1.2k; D..F are forbidden.
// RULE10 - Forbidden rate code keeps old rate; width and user bits still update.
// RULE11 - Reset high clears configuration and returns to 9600 bit/s.
// RULE12 - Host waits 2 ms or 7 us after reset before raising select.
// RULE13 - Host waits 7 us after raising select before sending the word.
// RULE14 - Host sends the word as 8 data bits, no parity, one stop.
// RULE15 - Word is sent and decoded at the current rate, 9600 after reset.
// RULE16 - Host holds select high 1 us after the word before lowering it.
// RULE17 - Host keeps reset and select low during data transfer.
// RULE18 - Reprogramming by raising select again is accepted at any time.
// RULE19 - Host switches its own serial port to the new rate afterwards.
// RULE20 - Software should prefer the short fixed pulse to save power.
// RULE21 - Infrared output is active high and carries the shortened pulses.
// RULE22 - Transceiver gives active-low receive pulses of at least 1.63 us.
// RULE23 - Each zero bit, start included, gives one pulse from cell start.
// RULE24 - Each received pulse drives receive out low one bit from its fall.
`include "irc_params.svh"
module irc_endec_top
	import irc_pkg::*;
#(
	parameter int unsigned CLK_FREQ_HZ = `IRC_CLK_HZ // Scale down to shorten simulation
) (
	input  wire logic clock,         // System clock, 50 MHz
	input  wire logic arst_n,        // Asynchronous reset, active low
	input  wire logic ce,            // Clock enable, freezes all state when low
	input  wire logic reset_in,      // Device reset pin, active high
	input  wire logic config_select, // High selects control word mode
	input  wire logic uart_tx_in,    // Serial data from host, idle high
	input  wire logic ir_rx_in,      // Infrared receive pulses, active low
	output logic      ir_tx_out,     // Infrared transmit pulses, active high
	output logic      uart_rx_out,   // Stretched serial data to host
	output logic      user_out_a_n,  // First user pin, active low
	output logic      user_out_b_n   // Second user pin, active low
);
	// Fixed pulse length, rounded up to whole clocks
	localparam longint unsigned PULSE_FIX_CYC_L =
		(longint'(`IRC_PULSE_FIX_NS) * longint'(CLK_FREQ_HZ) + longint'(`IRC_NS_PER_S) - 1)
		/ longint'(`IRC_NS_PER_S);
	localparam irc_cnt_t PULSE_FIX_CYC = (PULSE_FIX_CYC_L < 1) ? irc_cnt_t'(1) :
		irc_cnt_t'(PULSE_FIX_CYC_L);

	// Clocks per bit for a rate code, rounded to nearest
	function automatic irc_cnt_t rate_cycles(input irc_rate_t code);
		int unsigned baud;
		baud = `IRC_BAUD_6;
		case (code)
			4'h0: baud = `IRC_BAUD_0; // see RULE9
			4'h1: baud = `IRC_BAUD_1;
			4'h2: baud = `IRC_BAUD_2;
			4'h3: baud = `IRC_BAUD_3;
			4'h4: baud = `IRC_BAUD_4;
			4'h5: baud = `IRC_BAUD_5;
			4'h6: baud = `IRC_BAUD_6;
			4'h7: baud = `IRC_BAUD_7;
			4'h8: baud = `IRC_BAUD_8;
			4'h9: baud = `IRC_BAUD_9;
			4'hA: baud = `IRC_BAUD_A;
			4'hB: baud = `IRC_BAUD_B;
			4'hC: baud = `IRC_BAUD_C;
			default: baud = `IRC_BAUD_6; // Unreachable: forbidden codes are never stored
		endcase
		return irc_cnt_t'((CLK_FREQ_HZ + baud / 2) / baud);
	endfunction : rate_cycles

	// Configuration state
	irc_rate_t rate_r, rate_nxt;           // Active rate
	irc_rate_t pend_rate_r, pend_rate_nxt; // Rate waiting for select to fall
	logic      pulse_sel_r, pulse_sel_nxt;
	logic      user_a_r, user_a_nxt;
	logic      user_b_r, user_b_nxt;
	logic      sel_prev_r, sel_prev_nxt;

	// Encoder state
	logic      tx_prev_r, tx_prev_nxt;
	logic      cell_act_r, cell_act_nxt;
	irc_cnt_t  cell_cnt_r, cell_cnt_nxt;
	irc_cnt_t  pulse_cnt_r, pulse_cnt_nxt;
	logic      ir_tx_r, ir_tx_nxt;

	// Shared combinational terms
	logic      data_mode;
	logic      cfg_mode;
	irc_cnt_t  bit_cycles;
	logic [17:0] frac_prod;
	irc_cnt_t  frac_cyc;
	irc_cnt_t  pulse_cyc;
	irc_byte_t cfg_byte;
	logic      cfg_valid;
	irc_rate_t cfg_rate;
	logic      tx_fall;
	logic      cell_end;
	logic      pulse_start;

	// Mode decode; the reset pin overrides both modes
	assign data_mode  = !reset_in && !config_select; // see RULE1
	assign cfg_mode   = !reset_in && config_select;  // see RULE2
	assign bit_cycles = rate_cycles(rate_r);         // see RULE15

	// Pulse width: 3/16 of the bit cell or the fixed short pulse
	assign frac_prod = 18'(bit_cycles) * 18'(`IRC_PULSE_NUM);
	assign frac_cyc  = irc_cnt_t'(frac_prod / 18'(`IRC_PULSE_DEN));
	assign pulse_cyc = pulse_sel_r ? PULSE_FIX_CYC :
		((frac_cyc == '0) ? irc_cnt_t'(1) : frac_cyc); // see RULE6

	// Control byte receiver runs at the rate in force when select rose
	irc_cfg_rx u_cfg_rx (
		.clock      (clock),
		.arst_n     (arst_n),
		.ce         (ce),
		.enable     (cfg_mode),
		.rx_in      (uart_tx_in),
		.bit_cycles (bit_cycles),
		.byte_data  (cfg_byte),
		.byte_valid (cfg_valid)
	);

	// Receive direction stretcher, idle high outside data mode
	irc_ir_stretch u_ir_stretch (
		.clock      (clock),
		.arst_n     (arst_n),
		.ce         (ce),
		.enable     (data_mode),
		.ir_rx_in   (ir_rx_in),
		.bit_cycles (bit_cycles),
		.rx_out     (uart_rx_out)
	);

	assign cfg_rate = cfg_byte[`IRC_RATE_MSB:`IRC_RATE_LSB]; // see RULE4

	// Configuration next state; bit 7 of the byte is never read
	always_comb begin
		rate_nxt      = rate_r;
		pend_rate_nxt = pend_rate_r;
		pulse_sel_nxt = pulse_sel_r;
		user_a_nxt    = user_a_r;
		user_b_nxt    = user_b_r;
		sel_prev_nxt  = config_select;
		if (reset_in) begin
			rate_nxt      = `IRC_RATE_RESET; // see RULE11
			pend_rate_nxt = `IRC_RATE_RESET;
			pulse_sel_nxt = 1'b0;
			user_a_nxt    = 1'b0;
			user_b_nxt    = 1'b0;
			sel_prev_nxt  = 1'b0;
		end else begin
			// Each new select session starts from the active rate
			if (config_select && !sel_prev_r) begin
				pend_rate_nxt = rate_r; // see RULE18
			end
			if (cfg_valid) begin
				pulse_sel_nxt = cfg_byte[`IRC_BIT_PULSE];  // see RULE3
				user_a_nxt    = cfg_byte[`IRC_BIT_USER_A]; // see RULE7
				user_b_nxt    = cfg_byte[`IRC_BIT_USER_B];
				if (cfg_rate <= `IRC_RATE_MAX) begin
					pend_rate_nxt = cfg_rate; // see RULE10
				end
			end
			// Rate switches on the falling edge of select only
			if (!config_select && sel_prev_r) begin
				rate_nxt = pend_rate_r; // see RULE5
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rate_r      <= `IRC_RATE_RESET;
			pend_rate_r <= `IRC_RATE_RESET;
			pulse_sel_r <= 1'b0;
			user_a_r    <= 1'b0;
			user_b_r    <= 1'b0;
			sel_prev_r  <= 1'b0;
		end else if (ce) begin
			rate_r      <= rate_nxt;
			pend_rate_r <= pend_rate_nxt;
			pulse_sel_r <= pulse_sel_nxt;
			user_a_r    <= user_a_nxt;
			user_b_r    <= user_b_nxt;
			sel_prev_r  <= sel_prev_nxt;
		end
	end

	// Encoder: bit cells re-align on every falling edge, so no framing is needed
	assign tx_fall     = tx_prev_r && !uart_tx_in;
	assign cell_end    = cell_act_r && (cell_cnt_r == bit_cycles - 1'b1);
	assign pulse_start = data_mode && (tx_fall || (cell_end && !uart_tx_in)); // see RULE23

	always_comb begin
		tx_prev_nxt   = uart_tx_in;
		cell_act_nxt  = cell_act_r;
		cell_cnt_nxt  = cell_cnt_r;
		pulse_cnt_nxt = pulse_cnt_r;
		if (!data_mode) begin
			cell_act_nxt  = 1'b0;
			cell_cnt_nxt  = '0;
			pulse_cnt_nxt = '0;
		end else begin
			if (tx_fall) begin
				cell_act_nxt = 1'b1;
				cell_cnt_nxt = '0;
			end else if (cell_end) begin
				cell_cnt_nxt = '0;
				cell_act_nxt = !uart_tx_in; // A high cell ends the run until the next edge
			end else if (cell_act_r) begin
				cell_cnt_nxt = cell_cnt_r + 1'b1;
			end
			if (pulse_start) begin
				pulse_cnt_nxt = pulse_cyc;
			end else if (pulse_cnt_r != '0) begin
				pulse_cnt_nxt = pulse_cnt_r - 1'b1;
			end
		end
		ir_tx_nxt = (pulse_cnt_nxt != '0); // see RULE21
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			tx_prev_r   <= 1'b1;
			cell_act_r  <= 1'b0;
			cell_cnt_r  <= '0;
			pulse_cnt_r <= '0;
			ir_tx_r     <= 1'b0;
		end else if (ce) begin
			tx_prev_r   <= tx_prev_nxt;
			cell_act_r  <= cell_act_nxt;
			cell_cnt_r  <= cell_cnt_nxt;
			pulse_cnt_r <= pulse_cnt_nxt;
			ir_tx_r     <= ir_tx_nxt;
		end
	end

	// Outputs straight from flip-flops
	assign ir_tx_out    = ir_tx_r;
	assign user_out_a_n = !user_a_r; // see RULE8
	assign user_out_b_n = !user_b_r; // see RULE8
endmodule : irc_endec_top

// file: test/irc_endec_sva.sv
// Port-level checker for the infrared pulse encoder/decoder
module irc_endec_chk #(
	parameter int unsigned CLK_FREQ_HZ = 50_000_000 // Same scaling as the design
) (
	input wire logic clock,         // System clock
	input wire logic arst_n,        // Asynchronous reset, active low
	input wire logic ce,            // Clock enable
	input wire logic reset_in,      // Device reset pin
	input wire logic config_select, // Control word mode
	input wire logic uart_tx_in,    // Serial data from host
	input wire logic ir_rx_in,      // Infrared receive input
	input wire logic ir_tx_out,     // Infrared transmit output
	input wire logic uart_rx_out,   // Stretched serial output
	input wire logic user_out_a_n,  // First user pin
	input wire logic user_out_b_n   // Second user pin
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	// Minimum widths assume the bench runs the scaled clock, where the shortest cell is 17 cycles
	cfg_quiet_a: assert property (config_select [*3] |-> !ir_tx_out && uart_rx_out)
		else $error("outputs active in control mode");
	rst_quiet_a: assert property (reset_in [*3] |-> !ir_tx_out && uart_rx_out
		&& user_out_a_n && user_out_b_n) else $error("outputs not cleared by reset pin");
	tx_start_a: assert property (!config_select && !$past(config_select) && !reset_in
		&& $fell(uart_tx_in) |=> ir_tx_out) else $error("no pulse after falling data edge");
	tx_rise_a: assert property ($rose(ir_tx_out) |-> !$past(config_select)
		&& !$past(reset_in)) else $error("pulse started outside data mode");
	tx_min_a: assert property ($rose(ir_tx_out) |-> ir_tx_out [*3])
		else $error("transmit pulse too short");
	rx_low_a: assert property (!config_select && !$past(config_select) && !reset_in
		&& $fell(ir_rx_in) |=> !uart_rx_out) else $error("receive pulse not stretched");
	rx_min_a: assert property ($fell(uart_rx_out) |-> (!uart_rx_out) [*8])
		else $error("stretched cell too short");
	pins_hold_a: assert property (!config_select && !$past(config_select)
		&& !reset_in && !$past(reset_in) && !$past(reset_in, 2)
		|-> $stable(user_out_a_n) && $stable(user_out_b_n)) else $error("user pin moved");
endmodule : irc_endec_chk

bind irc_endec_top irc_endec_chk #(.CLK_FREQ_HZ(CLK_FREQ_HZ)) chk_u (
	.clock(clock), .arst_n(arst_n), .ce(ce), .reset_in(reset_in),
	.config_select(config_select), .uart_tx_in(uart_tx_in), .ir_rx_in(ir_rx_in),
	.ir_tx_out(ir_tx_out), .uart_rx_out(uart_rx_out),
	.user_out_a_n(user_out_a_n), .user_out_b_n(user_out_b_n));

// file: test/irc_host_model.sv
// Host serial port model: drives the select pin and the transmit line
module irc_host_model (
	input  wire logic clock,         // System clock
	output logic      config_select, // Control word mode select
	output logic      uart_tx_in     // Serial line toward the device, idle high
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		config_select = 1'b0;
		uart_tx_in    = 1'b1;
	end

	// One frame: start, 8 data bits LSB first, no parity, one stop
	task automatic send_byte(input int bc, input logic [7:0] val);
		logic [9:0] frame;
		frame = {1'b1, val, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge clock) uart_tx_in <= frame[i];
			repeat (bc - 1) @(negedge clock);
		end
	endtask : send_byte

	// Control session at the rate now in force; the caller tracks the new rate
	task automatic configure(input int bc, input logic [7:0] w0, input logic [7:0] w1,
		input bit two);
		@(negedge clock) config_select <= 1'b1;
		repeat (350) @(negedge clock);
		send_byte(bc, w0);
		if (two) begin
			send_byte(bc, w1);
		end
		repeat (50) @(negedge clock);
		config_select <= 1'b0;
		repeat (4) @(negedge clock);
	endtask : configure
endmodule : irc_host_model

// file: test/tb_ir_pulse_endec_baud_config.sv
// Self-checking bench for the infrared pulse encoder/decoder
module tb_ir_pulse_endec_baud_config;
	timeunit 1ns;
	timeprecision 1ns;
	// Scaled clock keeps the slow rates short
	localparam int unsigned CLK_HZ = 2_000_000;
	localparam int FIX_W = int'((64'd1627 * CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000);

	logic clock, arst_n, ce, reset_in, ir_rx_in, config_select, uart_tx_in;
	logic ir_tx_out, uart_rx_out, user_out_a_n, user_out_b_n;
	int   error_cnt = 0;
	int   comparisons = 0;
	int   cycles = 0;
	int   baud [13] = '{115200, 57600, 38400, 19200, 14400, 12800, 9600,
		7200, 4800, 3600, 2400, 1800, 1200};

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	irc_endec_top #(.CLK_FREQ_HZ(CLK_HZ)) dut_u (
		.clock(clock), .arst_n(arst_n), .ce(ce), .reset_in(reset_in),
		.config_select(config_select), .uart_tx_in(uart_tx_in), .ir_rx_in(ir_rx_in),
		.ir_tx_out(ir_tx_out), .uart_rx_out(uart_rx_out),
		.user_out_a_n(user_out_a_n), .user_out_b_n(user_out_b_n));

	irc_host_model host_u (.clock(clock), .config_select(config_select),
		.uart_tx_in(uart_tx_in));

	// Hang guard, above the roughly 70k cycles the run needs
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 90_000) begin
			error_cnt++;
			give_verdict();
		end
	end

	function automatic int bitc(input int b);
		return (CLK_HZ + b / 2) / b;
	endfunction : bitc

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// Sends 0xFE: start and bit 0 are zero, so exactly two pulses
	task automatic meas_tx(input int bc, input int exp_w);
		int   w, n;
		logic pv;
		w = 0;
		n = 0;
		pv = 1'b0;
		fork
			host_u.send_byte(bc, 8'hFE);
			repeat (bc * 11) begin
				@(negedge clock);
				if (ir_tx_out === 1'b1 && !pv) n++;
				if (ir_tx_out === 1'b1 && n == 1) w++;
				pv = ir_tx_out;
			end
		join
		check(w, exp_w);
		check(n, 2);
	endtask : meas_tx

	// Four-cycle receive pulse, long enough at the scaled clock
	task automatic meas_rx(input int exp_w);
		int w;
		w = 0;
		@(negedge clock) ir_rx_in = 1'b0;
		for (int i = 0; i < exp_w + 20; i++) begin
			@(negedge clock);
			if (i == 3) ir_rx_in = 1'b1;
			if (uart_rx_out === 1'b0) w++;
		end
		check(w, exp_w);
	endtask : meas_rx

	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict

	initial begin
		int cur;
		arst_n = 1'b0;
		ce = 1'b1;
		reset_in = 1'b0;
		ir_rx_in = 1'b1;
		repeat (3) @(negedge clock);
		arst_n = 1'b1;
		@(negedge clock);
		check({ir_tx_out, uart_rx_out, user_out_b_n, user_out_a_n}, 4'h7);
		repeat (350) @(negedge clock);
		cur = bitc(9600);
		meas_tx(cur, cur * 3 / 16);
		meas_rx(cur);
		$display("defaults test done");
		// Top bit set must not disturb anything
		host_u.configure(cur, 8'h96, 8'h00, 1'b0);
		check({user_out_b_n, user_out_a_n}, 2'b11);
		meas_tx(cur, FIX_W);
		$display("ignored bit test done");
		// Second word at the old rate proves the rate waits for select to drop
		host_u.configure(cur, 8'hF0, 8'h60, 1'b1);
		check({user_out_b_n, user_out_a_n}, 2'b00);
		cur = bitc(baud[0]);
		meas_tx(cur, cur * 3 / 16);
		meas_rx(cur);
		$display("deferred rate test done");
		// Forbidden code keeps the rate, other fields still update
		host_u.configure(cur, 8'h3D, 8'h00, 1'b0);
		check({user_out_b_n, user_out_a_n}, 2'b10);
		meas_rx(cur);
		meas_tx(cur, FIX_W);
		$display("forbidden code test done");
		// Clock enable low must hold a stretched cell part way through
		@(negedge clock) ir_rx_in = 1'b0;
		repeat (4) @(negedge clock);
		ir_rx_in = 1'b1;
		ce = 1'b0;
		repeat (40) @(negedge clock);
		check(uart_rx_out, 1'b0);
		ce = 1'b1;
		repeat (20) @(negedge clock);
		check(uart_rx_out, 1'b1);
		$display("clock enable test done");
		// Reset pin restores defaults
		@(negedge clock) reset_in = 1'b1;
		repeat (5) @(negedge clock);
		reset_in = 1'b0;
		repeat (350) @(negedge clock);
		check({user_out_b_n, user_out_a_n}, 2'b11);
		cur = bitc(9600);
		meas_rx(cur);
		meas_tx(cur, cur * 3 / 16);
		$display("reset pin test done");
		// Every legal code, each programmed at the rate before it
		for (int i = 0; i < 13; i++) begin
			host_u.configure(cur, {4'h1, i[3:0]}, 8'h00, 1'b0);
			cur = bitc(baud[i]);
			meas_rx(cur);
		end
		$display("rate table test done");
		give_verdict();
	end
endmodule : tb_ir_pulse_endec_baud_config
